// ### bench/far_side.sv
`timescale 1ns/10ps
`default_nettype none

module far_side (
    input wire logic i_core_clk,
    output logic o_src,
    output logic o_gate
);
    // source stands still low between pulses; each level held at least 4 clocks
    initial begin
        o_src = 1'b0;
        o_gate = 1'b0;
    end

    task automatic pulse(input int n);
        repeat (n) begin
            @(posedge i_core_clk);
            o_src <= 1'b1;
            repeat (4) @(posedge i_core_clk);
            o_src <= 1'b0;
            // settle time so the count and terminal pulse have landed
            repeat (5) @(posedge i_core_clk);
        end
    endtask : pulse

    task automatic gate(input logic v);
        @(posedge i_core_clk);
        o_gate <= v;
        repeat (6) @(posedge i_core_clk);
    endtask : gate
endmodule : far_side

`default_nettype wire

// ### bench/tb.sv
`timescale 1ns/10ps
`default_nettype none

module tb;
    import dcps_pkg::*;
    logic core_clk;
    logic nrst;
    logic [ADDR_W-1:0] addr;
    logic rd;
    logic wr;
    logic [31:0] wdata;
    logic [3:0] be;
    logic [31:0] rdata;
    logic waitreq;
    logic src;
    logic gate;
    logic cnt_out;
    logic tc;
    logic armed;
    int n_mismatch = 0;
    int checked = 0;
    int cyc = 0;
    int tc_total = 0;
    int out_hi = 0;

    dual_count_pulse_sequencer u_dual_count_pulse_sequencer (
        .i_core_clk(core_clk), .i_nrst(nrst), .i_avs_address(addr),
        .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdata),
        .i_avs_byteenable(be), .o_avs_readdata(rdata), .o_avs_waitrequest(waitreq),
        .i_count_src(src), .i_gate(gate), .o_count_out(cnt_out),
        .o_terminal_count_event(tc), .o_armed(armed)
    );

    far_side far (.i_core_clk(core_clk), .o_src(src), .o_gate(gate));

    always #5 core_clk = ~core_clk;

    // pulse counter; ceiling is about nine times the expected run length
    always @(posedge core_clk) begin
        if (tc === 1'b1) tc_total++;
        if (cnt_out === 1'b1) out_hi++;
        cyc++;
        if (cyc == 5000) begin
            n_mismatch++;
            $display("ERROR %0t timeout", $time);
            report_and_stop();
        end
    end

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : report_and_stop

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR %0t %s: got %h expected %h", $time, what, got, exp);
        end
    endtask : chk

    // request stands until the rising edge that sees waitrequest low; data taken there
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                       input logic [3:0] b, output logic [31:0] q);
        @(posedge core_clk);
        addr <= a;
        wdata <= d;
        be <= b;
        wr <= w;
        rd <= ~w;
        do @(posedge core_clk); while (waitreq !== 1'b0);
        q = rdata;
        wr <= 1'b0;
        rd <= 1'b0;
    endtask : bus

    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, 4'hf, q);
    endtask : wr_reg

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input string what);
        logic [31:0] q;
        bus(1'b0, a, 32'h0000_0000, 4'hf, q);
        chk(q, e, what);
    endtask : rd_chk

    // pins launched at the last edge settle by the falling edge
    task automatic pin_chk(input logic a, input logic o, input string what);
        @(negedge core_clk);
        chk({30'h0, armed, cnt_out}, {30'h0, a, o}, what);
    endtask : pin_chk

    task automatic setup(input logic [31:0] ctrl, input logic [15:0] l, input logic [15:0] h);
        wr_reg(OFS_CTRL, ctrl);
        wr_reg(OFS_LOAD, {16'h0, l});
        wr_reg(OFS_HOLD, {16'h0, h});
        wr_reg(OFS_CMD, 32'h0000_0001);
    endtask : setup

    task automatic t_reset;
        logic [31:0] q;
        rd_chk(OFS_STATUS, RDATA_ZERO, "status at reset");
        rd_chk(OFS_COUNT, {16'h0, RST_COUNT}, "count at reset");
        rd_chk(OFS_LOAD, {16'h0, RST_LOAD}, "load at reset");
        rd_chk(8'h83, RDATA_ZERO, "unmapped read");
        wr_reg(OFS_LOAD, 32'hffff_0003);
        bus(1'b1, OFS_LOAD, 32'h0000_ab77, 4'h2, q);
        rd_chk(OFS_LOAD, 32'h0000_ab03, "lane merge");
        wr_reg(OFS_HOLD, 32'hffff_5488);
        rd_chk(OFS_HOLD, 32'h0000_5488, "upper lanes ignored");
        rd_chk(OFS_CMD, RDATA_ZERO, "command reads zero");
        bus(1'b1, OFS_CMD, 32'h0000_000f, 4'he, q);
        rd_chk(OFS_STATUS, RDATA_ZERO, "arm without lane 0 ignored");
    endtask : t_reset

    task automatic t_strobe;
        int b;
        setup(32'h0000_0004, 16'h0003, 16'h0002);
        b = tc_total;
        far.pulse(3);
        rd_chk(OFS_COUNT, 32'h0000_0003, "strobe idle before gate");
        far.gate(1'b1);
        far.pulse(1);
        rd_chk(OFS_COUNT, 32'h0000_0002, "one source edge");
        far.gate(1'b0);
        far.pulse(2);
        chk(32'(tc_total - b), 32'h1, "strobe first tc");
        pin_chk(1'b1, 1'b1, "strobe delay end");
        rd_chk(OFS_COUNT, 32'h0000_0002, "hold reload");
        rd_chk(OFS_STATUS, 32'h0000_000f, "hold phase status");
        far.gate(1'b1);
        far.pulse(2);
        chk(32'(tc_total - b), 32'h2, "strobe second tc");
        pin_chk(1'b0, 1'b0, "strobe disarmed");
        rd_chk(OFS_COUNT, 32'h0000_0003, "load reloaded");
    endtask : t_strobe

    task automatic t_duty_free;
        int b;
        far.gate(1'b0);
        setup(32'h0000_0005, 16'h0002, 16'h0003);
        b = tc_total;
        pin_chk(1'b1, 1'b0, "duty armed");
        far.pulse(2);
        pin_chk(1'b1, 1'b1, "load phase end");
        rd_chk(OFS_COUNT, 32'h0000_0003, "hold reload");
        far.gate(1'b1);
        far.pulse(2);
        pin_chk(1'b1, 1'b1, "hold phase level");
        far.pulse(1);
        chk(32'(tc_total - b), 32'h2, "duty tc count");
        pin_chk(1'b1, 1'b0, "hold phase end");
        rd_chk(OFS_COUNT, 32'h0000_0002, "load reload");
        far.pulse(2);
        pin_chk(1'b1, 1'b1, "keeps cycling");
        wr_reg(OFS_CMD, 32'h0000_0002);
        pin_chk(1'b0, 1'b1, "disarm");
    endtask : t_duty_free

    // gate_low chosen here so the asserted level is low
    task automatic t_duty_level;
        int b;
        int b2;
        far.gate(1'b1);
        setup(32'h0000_0012, 16'h0002, 16'h0002);
        b = tc_total;
        b2 = out_hi;
        far.pulse(2);
        rd_chk(OFS_COUNT, 32'h0000_0002, "gate off halts");
        rd_chk(OFS_STATUS, 32'h0000_0005, "running while halted");
        far.gate(1'b0);
        far.pulse(1);
        rd_chk(OFS_COUNT, 32'h0000_0001, "gate on counts");
        far.gate(1'b1);
        far.pulse(2);
        rd_chk(OFS_COUNT, 32'h0000_0001, "value kept");
        far.gate(1'b0);
        far.pulse(1);
        chk(32'(tc_total - b), 32'h1, "level tc");
        chk(32'(out_hi - b2), 32'h1, "pulse output one clock");
        rd_chk(OFS_COUNT, 32'h0000_0002, "hold reload");
        wr_reg(OFS_CMD, 32'h0000_0002);
    endtask : t_duty_level

    task automatic t_oneshot;
        int b;
        far.gate(1'b0);
        setup(32'h0000_000f, 16'h0002, 16'h0001);
        b = tc_total;
        rd_chk(OFS_CTRL, 32'h0000_000f, "falling source control");
        far.pulse(2);
        rd_chk(OFS_COUNT, 32'h0000_0002, "needs gate edge");
        far.gate(1'b1);
        far.pulse(1);
        rd_chk(OFS_COUNT, 32'h0000_0001, "load counting");
        far.gate(1'b0);
        far.gate(1'b1);
        far.pulse(1);
        chk(32'(tc_total - b), 32'h1, "first tc");
        rd_chk(OFS_COUNT, 32'h0000_0001, "hold reload");
        far.pulse(1);
        chk(32'(tc_total - b), 32'h2, "second tc");
        pin_chk(1'b1, 1'b0, "stays armed");
        far.pulse(2);
        chk(32'(tc_total - b), 32'h2, "idle after cycle");
        rd_chk(OFS_COUNT, 32'h0000_0002, "idle count");
        far.gate(1'b0);
        far.gate(1'b1);
        far.pulse(1);
        rd_chk(OFS_COUNT, 32'h0000_0001, "retrigger");
        wr_reg(OFS_CMD, 32'h0000_0003);
        pin_chk(1'b0, 1'b0, "disarm beats arm");
    endtask : t_oneshot

    initial begin
        core_clk = 1'b0;
        nrst = 1'b0;
        addr = '0;
        rd = 1'b0;
        wr = 1'b0;
        wdata = '0;
        be = 4'h0;
        repeat (2) @(posedge core_clk);
        nrst <= 1'b1;
        @(posedge core_clk);
        t_reset();
        t_strobe();
        t_duty_free();
        t_duty_level();
        t_oneshot();
        report_and_stop();
    end
endmodule : tb

`default_nettype wire

// ### rtl/dcps_pkg.sv
package dcps_pkg;

    // counter width and terminal count threshold
    localparam int CNT_W = 16;
    localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;
    localparam logic [CNT_W-1:0] RST_LOAD = 16'h0000;
    localparam logic [CNT_W-1:0] RST_HOLD = 16'h0000;
    localparam logic [CNT_W-1:0] RST_COUNT = 16'h0000;

    // avalon-mm byte offsets
    localparam int ADDR_W = 8;
    localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_LOAD = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_HOLD = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_CMD = 8'h0c;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_COUNT = 8'h14;

    localparam logic [31:0] RDATA_ZERO = 32'h0000_0000;

    // control register fields
    localparam int CTRL_MODE_LO = 0;
    localparam int CTRL_MODE_HI = 1;
    localparam int CTRL_TOGGLE = 2;
    localparam int CTRL_SRC_FALL = 3;
    localparam int CTRL_GATE_LOW = 4;

    // command register fields (write only, self clearing)
    localparam int CMD_ARM = 0;
    localparam int CMD_DISARM = 1;

    // status register fields
    localparam int STAT_ARMED = 0;
    localparam int STAT_HOLD_PH = 1;
    localparam int STAT_RUNNING = 2;
    localparam int STAT_OUT = 3;

    typedef enum logic [1:0] {
        MODE_STROBE = 2'h0,
        MODE_DUTY_FREE = 2'h1,
        MODE_DUTY_LEVEL = 2'h2,
        MODE_ONESHOT = 2'h3
    } mode_t;

    // gray order: idle -> wait -> load -> hold
    typedef enum logic [1:0] {
        ST_IDLE = 2'h0,
        ST_WAIT_GATE = 2'h1,
        ST_LOAD_PH = 2'h3,
        ST_HOLD_PH = 2'h2
    } seq_state_t;

endpackage : dcps_pkg

// ### rtl/dual_count_pulse_sequencer.sv
// Added by the designer: the Avalon-MM register port and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none

module dual_count_pulse_sequencer
    import dcps_pkg::*;
(
    input wire logic i_core_clk,
    input wire logic i_nrst,
    input wire logic [ADDR_W-1:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    input wire logic [3:0] i_avs_byteenable,
    output logic [31:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    input wire logic i_count_src,
    input wire logic i_gate,
    output logic o_count_out,
    output logic o_terminal_count_event,
    output logic o_armed
);

    typedef struct packed {
        mode_t mode;
        logic toggle_sel;
        logic src_fall;
        logic gate_low;
        logic [CNT_W-1:0] load;
        logic [CNT_W-1:0] hold;
        logic [CNT_W-1:0] count;
        seq_state_t st;
        logic out_lvl;
        logic tc_pulse;
        logic count_out;
        logic armed;
        logic wait_rq;
        logic [31:0] rdata;
    } seq_regs_t;

    seq_regs_t cur;
    seq_regs_t nxt;

    logic [1:0] pins_sync;
    logic src_edge;
    logic gate_edge;
    logic gate_level;
    logic req;
    logic wr_commit;
    logic cmd_wr;
    logic cnt_step;
    logic tc_now;
    logic running;

    // merge one write into a 16-bit register by byte lanes
    function automatic logic [CNT_W-1:0] merge_lanes(
        input logic [CNT_W-1:0] old,
        input logic [31:0] wd,
        input logic [3:0] be
    );
        logic [CNT_W-1:0] r;
        r = old;
        if (be[0]) begin
            r[7:0] = wd[7:0];
        end
        if (be[1]) begin
            r[15:8] = wd[15:8];
        end
        return r;
    endfunction : merge_lanes

    pin_sync u_pin_sync (
        .i_core_clk(i_core_clk),
        .i_nrst(i_nrst),
        .i_pins({i_gate, i_count_src}),
        .o_pins(pins_sync)
    );

    edge_pick u_src_edge (
        .i_core_clk(i_core_clk),
        .i_nrst(i_nrst),
        .i_level(pins_sync[0]),
        .i_fall_sel(cur.src_fall),
        .o_edge(src_edge)
    );

    // gate polarity is folded in as an edge sense, so an asserting edge is caught
    edge_pick u_gate_edge (
        .i_core_clk(i_core_clk),
        .i_nrst(i_nrst),
        .i_level(pins_sync[1]),
        .i_fall_sel(cur.gate_low),
        .o_edge(gate_edge)
    );

    assign gate_level = pins_sync[1] ^ cur.gate_low;
    assign req = i_avs_read | i_avs_write;
    // a write lands on the edge where the master sees waitrequest low
    assign wr_commit = i_avs_write & ~cur.wait_rq;
    assign cmd_wr = wr_commit & (i_avs_address == OFS_CMD);
    assign running = (cur.st == ST_LOAD_PH) | (cur.st == ST_HOLD_PH);
    // load value of zero behaves as one: terminal count on the first edge
    assign tc_now = cur.count <= CNT_ONE;
    // only the level gated mode looks at the gate level
    assign cnt_step = src_edge & ((cur.mode != MODE_DUTY_LEVEL) | gate_level);

    always_comb begin
        nxt = cur;
        nxt.tc_pulse = 1'b0;
        nxt.wait_rq = ~(req & cur.wait_rq);
        if (req & cur.wait_rq) begin
            case (i_avs_address)
                OFS_CTRL: begin
                    nxt.rdata = {27'h0, cur.gate_low, cur.src_fall, cur.toggle_sel, cur.mode};
                end
                OFS_LOAD: begin
                    nxt.rdata = {16'h0000, cur.load};
                end
                OFS_HOLD: begin
                    nxt.rdata = {16'h0000, cur.hold};
                end
                OFS_STATUS: begin
                    nxt.rdata = {28'h0000000, cur.out_lvl, running,
                                 cur.st == ST_HOLD_PH, cur.armed};
                end
                OFS_COUNT: begin
                    nxt.rdata = {16'h0000, cur.count};
                end
                default: begin
                    nxt.rdata = RDATA_ZERO;
                end
            endcase
        end

        case (cur.st)
            ST_WAIT_GATE: begin
                // the counter already holds the load value here
                if (gate_edge) begin
                    nxt.st = ST_LOAD_PH;
                end
            end
            ST_LOAD_PH: begin
                if (cnt_step) begin
                    if (tc_now) begin
                        nxt.count = cur.hold;
                        nxt.st = ST_HOLD_PH;
                        nxt.tc_pulse = 1'b1;
                        nxt.out_lvl = ~cur.out_lvl;
                    end else begin
                        nxt.count = cur.count - CNT_ONE;
                    end
                end
            end
            ST_HOLD_PH: begin
                if (cnt_step) begin
                    if (tc_now) begin
                        nxt.count = cur.load;
                        nxt.tc_pulse = 1'b1;
                        nxt.out_lvl = ~cur.out_lvl;
                        case (cur.mode)
                            MODE_STROBE: begin
                                nxt.st = ST_IDLE;
                            end
                            MODE_ONESHOT: begin
                                nxt.st = ST_WAIT_GATE;
                            end
                            default: begin
                                nxt.st = ST_LOAD_PH;
                            end
                        endcase
                    end else begin
                        nxt.count = cur.count - CNT_ONE;
                    end
                end
            end
            ST_IDLE: begin
                nxt.st = ST_IDLE;
            end
            default: begin
                nxt.st = ST_IDLE;
            end
        endcase
        // gate edges reach only ST_WAIT_GATE above, so a running cycle never sees them

        if (wr_commit) begin
            case (i_avs_address)
                OFS_CTRL: begin
                    if (i_avs_byteenable[0]) begin
                        nxt.mode = mode_t'(i_avs_writedata[CTRL_MODE_HI:CTRL_MODE_LO]);
                        nxt.toggle_sel = i_avs_writedata[CTRL_TOGGLE];
                        nxt.src_fall = i_avs_writedata[CTRL_SRC_FALL];
                        nxt.gate_low = i_avs_writedata[CTRL_GATE_LOW];
                    end
                end
                OFS_LOAD: begin
                    nxt.load = merge_lanes(cur.load, i_avs_writedata, i_avs_byteenable);
                end
                OFS_HOLD: begin
                    nxt.hold = merge_lanes(cur.hold, i_avs_writedata, i_avs_byteenable);
                end
                OFS_CMD: begin
                    // disarm wins over arm; arming an armed channel is ignored
                    if (i_avs_byteenable[0] & i_avs_writedata[CMD_DISARM]) begin
                        nxt.st = ST_IDLE;
                        nxt.count = cur.load;
                        nxt.tc_pulse = 1'b0;
                        nxt.out_lvl = cur.out_lvl;
                    end else if (i_avs_byteenable[0] & i_avs_writedata[CMD_ARM]
                                 & (cur.st == ST_IDLE)) begin
                        nxt.count = cur.load;
                        nxt.out_lvl = 1'b0;
                        if ((cur.mode == MODE_STROBE) | (cur.mode == MODE_ONESHOT)) begin
                            nxt.st = ST_WAIT_GATE;
                        end else begin
                            nxt.st = ST_LOAD_PH;
                        end
                    end
                end
                default: begin
                    nxt.mode = cur.mode;
                end
            endcase
        end

        nxt.armed = nxt.st != ST_IDLE;
        nxt.count_out = cur.toggle_sel ? nxt.out_lvl : nxt.tc_pulse;
    end

    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            cur <= '0;
            cur.mode <= MODE_STROBE;
            cur.load <= RST_LOAD;
            cur.hold <= RST_HOLD;
            cur.count <= RST_COUNT;
            cur.st <= ST_IDLE;
            cur.wait_rq <= 1'b1;
        end else begin
            cur <= nxt;
        end
    end

    assign o_avs_readdata = cur.rdata;
    assign o_avs_waitrequest = cur.wait_rq;
    assign o_count_out = cur.count_out;
    assign o_terminal_count_event = cur.tc_pulse;
    assign o_armed = cur.armed;

    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (!i_nrst);

    sequence s_load_tc;
        cur.st == ST_LOAD_PH && cnt_step && tc_now && !wr_commit;
    endsequence

    sequence s_hold_tc;
        cur.st == ST_HOLD_PH && cnt_step && tc_now && !wr_commit;
    endsequence

    a_wait_gate_idle: assert property (
        cur.st == ST_WAIT_GATE && !gate_edge && !wr_commit
        |=> cur.st == ST_WAIT_GATE && $stable(cur.count))
        else $error("counter left gate wait without a gate edge");

    a_strobe_disarm: assert property (
        s_hold_tc ##0 cur.mode == MODE_STROBE
        |=> cur.st == ST_IDLE && !o_armed && cur.count == $past(cur.load))
        else $error("strobe did not disarm and reload at second terminal count");

    a_running_gate_deaf: assert property (
        running && cur.mode != MODE_DUTY_LEVEL && !src_edge && !wr_commit
        |=> $stable(cur.count) && $stable(cur.st))
        else $error("gate activity disturbed a running cycle");

    a_duty_repeat: assert property (
        s_hold_tc ##0 (cur.mode == MODE_DUTY_FREE || cur.mode == MODE_DUTY_LEVEL)
        |=> cur.st == ST_LOAD_PH && o_armed && cur.count == $past(cur.load))
        else $error("duty cycle did not return to the load phase");

    a_load_to_hold: assert property (
        s_load_tc |=> cur.st == ST_HOLD_PH && cur.count == $past(cur.hold)
        ##0 o_terminal_count_event)
        else $error("first terminal count did not reload the hold value");

    a_toggle_flip: assert property (
        (s_load_tc or s_hold_tc) ##0 cur.toggle_sel
        |=> o_count_out != $past(o_count_out) ##1 o_count_out == $past(o_count_out))
        else $error("toggle output did not flip once at terminal count");

    a_free_decrement: assert property (
        cur.mode == MODE_DUTY_FREE && running && src_edge && !tc_now && !wr_commit
        |=> cur.count == $past(cur.count) - CNT_ONE)
        else $error("free duty cycle missed a source edge");

    a_level_halt: assert property (
        cur.mode == MODE_DUTY_LEVEL && !gate_level && !wr_commit
        |=> $stable(cur.count) && $stable(cur.st))
        else $error("level gated counter moved with gate deasserted");

    a_oneshot_rewait: assert property (
        s_hold_tc ##0 cur.mode == MODE_ONESHOT
        |=> cur.st == ST_WAIT_GATE && o_armed && cur.count == $past(cur.load))
        else $error("one-shot did not return to gate wait");

    a_count_on_edge: assert property (
        !src_edge && !wr_commit |=> $stable(cur.count))
        else $error("count changed without a source edge");

endmodule : dual_count_pulse_sequencer

`default_nettype wire

// ### rtl/edge_pick.sv
`timescale 1ns/10ps
`default_nettype none

module edge_pick (
    input wire logic i_core_clk,
    input wire logic i_nrst,
    input wire logic i_level,
    input wire logic i_fall_sel,
    output logic o_edge
);

    typedef struct packed {
        logic prev;
    } edge_state_t;

    edge_state_t cur;
    edge_state_t nxt;

    always_comb begin
        nxt = cur;
        nxt.prev = i_level;
    end

    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            cur <= '0;
        end else begin
            cur <= nxt;
        end
    end

    // a level already high out of reset reads as a rising edge
    assign o_edge = i_fall_sel ? (cur.prev & ~i_level) : (~cur.prev & i_level);

endmodule : edge_pick

`default_nettype wire

// ### rtl/pin_sync.sv
`timescale 1ns/10ps
`default_nettype none

module pin_sync (
    input wire logic i_core_clk,
    input wire logic i_nrst,
    input wire logic [1:0] i_pins,
    output logic [1:0] o_pins
);

    typedef struct packed {
        logic [1:0] meta;
        logic [1:0] stable;
    } sync_state_t;

    sync_state_t cur;
    sync_state_t nxt;

    // meta feeds only the second stage
    always_comb begin
        nxt = cur;
        nxt.meta = i_pins;
        nxt.stable = cur.meta;
    end

    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            cur <= '0;
        end else begin
            cur <= nxt;
        end
    end

    assign o_pins = cur.stable;

endmodule : pin_sync

`default_nettype wire
